// ===== hdl/pml_pkg.sv
package pml_pkg;

    localparam int SMP_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int OSR = 60;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_DV_NS = 90;
    // valid-data delay rounds up to whole cycles, never under one
    localparam int DV_CYC_I = ((T_DV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS)
        < 1 ? 1 : ((T_DV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] DV_CYC = CNT_W'(DV_CYC_I);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam int BIT_CNT_W = 6;
    localparam logic [BIT_CNT_W-1:0] OSR_M1 = BIT_CNT_W'(OSR - 1);
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 6'h00;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 6'h01;
    localparam logic [SMP_W-1:0] SMP_RST = 16'h0000;
    localparam logic [SMP_W-1:0] SIGN_FLIP = 16'h8000;
    localparam logic [SMP_W-1:0] ACC_RST = 16'h0000;

    typedef struct packed {
        logic dat;
        logic oe;
    } pml_pin_t;

    localparam pml_pin_t PIN_RST = '{dat: 1'b0, oe: 1'b0};

    typedef enum logic [1:0] {
        PH_RELEASED,
        PH_WAIT,
        PH_DRIVE
    } pml_phase_t;

endpackage

// ===== hdl/pml_fifo.sv
`timescale 1ns/1ps
module pml_fifo
    import pml_pkg::*;
#(
    parameter int W = 16,
    parameter int DEPTH = 16
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] PTR_ZERO = '0;
    localparam logic [AW-1:0] PTR_ONE = AW'(1);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_NONE = '0;
    localparam logic [AW:0] CNT_STEP = (AW+1)'(1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    logic push, pop;

    // ready is registered so the block's s_ready leaves a flop directly
    assign in_ready = ready_q;
    assign out_valid = (cnt_q != CNT_NONE);
    assign out_data = mem[rd_q];

    always_comb
    begin
        push = in_valid & ready_q;
        pop = out_ready & (cnt_q != CNT_NONE);
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            wr_d = (wr_q == PTR_LAST) ? PTR_ZERO : wr_q + PTR_ONE;
        end
        if (pop)
        begin
            rd_d = (rd_q == PTR_LAST) ? PTR_ZERO : rd_q + PTR_ONE;
        end
        if (push & ~pop)
        begin
            cnt_d = cnt_q + CNT_STEP;
        end
        else if (pop & ~push)
        begin
            cnt_d = cnt_q - CNT_STEP;
        end
        ready_d = (cnt_d != CNT_FULL);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wr_q <= PTR_ZERO;
            rd_q <= PTR_ZERO;
            cnt_q <= CNT_NONE;
            ready_q <= 1'b1;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    // storage carries no reset; only the pointers, count and ready need a defined value
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end

    a_fifo_full_stall: assert property (@(posedge clock) disable iff (!rst_n)
        (cnt_q == CNT_FULL) |-> !in_ready)
        else $error("fifo accepts while full");

    a_fifo_count_up: assert property (@(posedge clock) disable iff (!rst_n)
        (push && !pop) |=> (cnt_q == $past(cnt_q) + CNT_STEP))
        else $error("fifo count did not rise on push");

endmodule

// ===== hdl/pml_pdm_tx.sv
`timescale 1ns/1ps
module pml_pdm_tx
    import pml_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bclk,
    input wire logic falling_variant,
    input wire logic [SMP_W-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe
);
    logic bclk_q, bclk_d;
    pml_phase_t ph_q, ph_d;
    logic [CNT_W-1:0] dv_q, dv_d;
    logic [SMP_W-1:0] acc_q, acc_d;
    logic [SMP_W-1:0] smp_q, smp_d;
    logic [BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
    pml_pin_t pin_q, pin_d;
    logic rise, fall, rel_edge, drv_edge, fire;
    logic [SMP_W:0] sum;
    logic [SMP_W-1:0] level;
    logic [SMP_W-1:0] f_data;
    logic f_valid, f_ready, fifo_ready;

    // every property here runs on the system clock and sleeps in reset
    default clocking dc @(posedge clock);
    endclocking

    default disable iff (!rst_n);

    pml_fifo #(
        .W(SMP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(s_valid),
        .in_ready(fifo_ready),
        .in_data(s_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // the fifo's ready is itself a flop
    assign s_ready = fifo_ready;
    assign data_out = pin_q.dat;
    assign data_oe = pin_q.oe;

    // the shared line is read back nowhere; the host samples it
    logic unused_in;
    assign unused_in = data_in;

    always_comb
    begin
        rise = bclk & ~bclk_q;
        fall = ~bclk & bclk_q;
        // the variant picks which edge releases and which drives
        rel_edge = falling_variant ? fall : rise;
        drv_edge = falling_variant ? rise : fall;
        // offset binary: signed zero maps to half scale
        level = smp_q ^ SIGN_FLIP;
        sum = {1'b0, acc_q} + {1'b0, level};
        bclk_d = bclk;
        ph_d = ph_q;
        dv_d = dv_q;
        acc_d = acc_q;
        smp_d = smp_q;
        bit_cnt_d = bit_cnt_q;
        pin_d = pin_q;
        f_ready = 1'b0;
        fire = 1'b0;
        case (ph_q)
            PH_RELEASED:
            begin
                if (drv_edge)
                begin
                    ph_d = PH_WAIT;
                    dv_d = DV_CYC - CNT_ONE;
                end
            end
            PH_WAIT:
            begin
                if (rel_edge)
                begin
                    ph_d = PH_RELEASED;
                end
                else if (dv_q == CNT_ZERO)
                begin
                    fire = 1'b1;
                    ph_d = PH_DRIVE;
                end
                else
                begin
                    dv_d = dv_q - CNT_ONE;
                end
            end
            PH_DRIVE:
            begin
                if (rel_edge)
                begin
                    ph_d = PH_RELEASED;
                end
            end
            default:
            begin
                ph_d = PH_RELEASED;
            end
        endcase
        // release right at our edge, the partner waits its valid delay
        if (rel_edge || ph_q == PH_RELEASED)
        begin
            pin_d.oe = 1'b0;
        end
        if (fire)
        begin
            // first-order loop: the carry is the bit, ones track level
            pin_d.dat = sum[SMP_W];
            pin_d.oe = 1'b1;
            acc_d = sum[SMP_W-1:0];
            if (bit_cnt_q == OSR_M1)
            begin
                bit_cnt_d = BIT_CNT_ZERO;
                // an empty fifo holds the last sample rather than jump
                if (f_valid)
                begin
                    f_ready = 1'b1;
                    smp_d = f_data;
                end
            end
            else
            begin
                bit_cnt_d = bit_cnt_q + BIT_CNT_ONE;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            // track the pin in reset so its idle level is no false edge
            bclk_q <= bclk_d;
            ph_q <= PH_RELEASED;
            dv_q <= CNT_ZERO;
            acc_q <= ACC_RST;
            smp_q <= SMP_RST;
            bit_cnt_q <= BIT_CNT_ZERO;
            pin_q <= PIN_RST;
        end
        else
        begin
            bclk_q <= bclk_d;
            ph_q <= ph_d;
            dv_q <= dv_d;
            acc_q <= acc_d;
            smp_q <= smp_d;
            bit_cnt_q <= bit_cnt_d;
            pin_q <= pin_d;
        end
    end

    sequence s_drive_window;
        drv_edge ##1 !rel_edge ##1 !rel_edge;
    endsequence

    sequence s_released_then_on;
        !pin_q.oe ##1 pin_q.oe;
    endsequence

    a_release_edge: assert property (rel_edge |=> !pin_q.oe)
        else $error("line not released after release edge");

    a_drive_delay: assert property (s_drive_window |-> pin_q.oe)
        else $error("data not driven after drive edge");

    a_drive_after_gap: assert property (
        (drv_edge && !pin_q.oe) |=> s_released_then_on or rel_edge)
        else $error("drive did not follow a released cycle");

    a_drive_half: assert property (
        $rose(pin_q.oe) |-> (bclk_q == falling_variant))
        else $error("drive started in the wrong half period");

    a_bit_stable: assert property (
        (pin_q.oe && $past(pin_q.oe)) |-> $stable(pin_q.dat))
        else $error("data bit changed while driven");

    // the wait counter runs exactly the valid delay after the drive edge
    a_one_bit_per: assert property (
        fire |-> $past(drv_edge, DV_CYC_I))
        else $error("bit produced without a drive edge");

    a_min_zero: assert property (
        (fire && level == SMP_RST) |=> !pin_q.dat)
        else $error("minimum input produced a one");

    a_osr_reload: assert property (
        f_ready |-> (fire && bit_cnt_q == OSR_M1))
        else $error("sample taken before sixty bits");

endmodule

// ===== sim/pml_host.sv
`timescale 1ns/1ps
module pml_host
    import pml_pkg::*;
#(
    parameter int HALF = 4
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic cap_fall,
    input wire logic data_out,
    input wire logic data_oe,
    output logic bclk,
    output logic line,
    output int bits,
    output int ones,
    output int clashes,
    output int rises
);
    int ph;
    logic last_q;
    logic oe_q;
    initial
    begin
        bits = 0;
        ones = 0;
        clashes = 0;
        rises = 0;
        last_q = 1'b0;
        oe_q = 1'b0;
    end
    // nobody pulls the wire: a released line flips, never shows a stale bit
    assign line = data_oe ? data_out : ~last_q;
    always @(posedge clock)
    begin
        last_q <= line;
        oe_q <= data_oe;
        if (!rst_n)
        begin
            // idle level makes the first toggle a drive edge
            bclk <= ~cap_fall;
            ph <= 0;
        end
        else if (run)
        begin
            rises <= rises + int'(data_oe && !oe_q);
            // 8 clocks per bit: 1.25 MHz, band near 10 kHz
            ph <= (ph == HALF - 1) ? 0 : ph + 1;
            if (ph == HALF - 1)
            begin
                bclk <= ~bclk;
                if (bclk == cap_fall)
                begin
                    bits <= bits + 1;
                    ones <= ones + int'(line);
                    clashes <= clashes + int'(!data_oe);
                end
                else
                    clashes <= clashes + int'(data_oe);
            end
        end
    end
endmodule

// ===== sim/pml_pdm_tx_bench.sv
`timescale 1ns/1ps
module pml_pdm_tx_bench;
    import pml_pkg::*;
    localparam int HALF = 4;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic falling_variant = 1'b0;
    logic [SMP_W-1:0] s_data = 16'h0000;
    logic s_valid = 1'b0;
    logic run = 1'b0;
    logic s_ready;
    logic data_out;
    logic data_oe;
    logic bclk;
    logic line;
    int bits, ones, clashes, rises;
    int num_errors = 0;
    int checks = 0;
    always #50 clock = ~clock;
    pml_pdm_tx dut (.clock(clock), .rst_n(rst_n), .bclk(bclk),
        .falling_variant(falling_variant), .s_data(s_data),
        .s_valid(s_valid), .s_ready(s_ready), .data_in(line),
        .data_out(data_out), .data_oe(data_oe));
    pml_host #(.HALF(HALF)) host (.clock(clock), .rst_n(rst_n), .run(run),
        .cap_fall(falling_variant), .data_out(data_out),
        .data_oe(data_oe), .bclk(bclk), .line(line), .bits(bits),
        .ones(ones), .clashes(clashes), .rises(rises));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset(input logic variant);
        @(posedge clock);
        rst_n <= 1'b0;
        run <= 1'b0;
        falling_variant <= variant;
        repeat (12) @(posedge clock);
        check(data_oe, 1'b0);
        check(s_ready, 1'b1);
        rst_n <= 1'b1;
        run <= 1'b1;
        $display("test reset done");
    endtask
    task automatic push(input logic [SMP_W-1:0] v);
        int n;
        @(posedge clock);
        s_valid <= 1'b1;
        s_data <= v;
        for (n = 0; n < 8000; n++)
        begin
            @(posedge clock);
            if (s_ready === 1'b1)
                break;
        end
        if (n == 8000)
        begin
            num_errors++;
            tally_and_finish();
        end
        s_valid <= 1'b0;
    endtask
    task automatic wait_bits(input int n);
        int t;
        int b0;
        b0 = bits;
        for (t = 0; bits < b0 + n; t++)
        begin
            if (t > n * 4 * HALF + 50)
            begin
                num_errors++;
                tally_and_finish();
            end
            @(posedge clock);
        end
    endtask
    // a sample owns 60 bits, so 125 bits flush older ones
    task automatic t_density(input logic [15:0] v, input int lo, input int hi);
        int o0;
        int r0;
        int b0;
        push(v);
        wait_bits(125);
        o0 = ones;
        r0 = rises;
        b0 = bits;
        wait_bits(60);
        check(ones - o0 >= lo && ones - o0 <= hi, 1'b1);
        check(rises - r0, bits - b0);
        $display("test density %h done", v);
    endtask
    task automatic t_fifo;
        int k;
        @(posedge clock);
        run <= 1'b0;
        for (k = 0; k < 16; k++)
            push(16'h8000);
        repeat (2) @(posedge clock);
        check(s_ready, 1'b0);
        s_valid <= 1'b1;
        repeat (20) @(posedge clock);
        check(s_ready, 1'b0);
        run <= 1'b1;
        push(16'h8000);
        $display("test fifo done");
    endtask
    initial
    begin
        do_reset(1'b0);
        t_density(16'h8000, 0, 0);
        t_density(16'h0000, 30, 30);
        t_density(16'h7fff, 59, 60);
        t_fifo();
        do_reset(1'b1);
        t_density(16'h0000, 30, 30);
        t_density(16'h8000, 0, 0);
        check(clashes, 0);
        tally_and_finish();
    end
endmodule
